// [core/mode_sel_pkg.sv]
// Package holding constants, types and encodings for the operating mode selector
package mode_sel_pkg;
  // APB register byte offsets
  localparam logic [7:0] ADDR_PRIO_MODE  = 8'h00;
  localparam logic [7:0] ADDR_FACT_TEST  = 8'h04;
  localparam logic [7:0] ADDR_PRIV_CTRL  = 8'h08;
  localparam logic [7:0] ADDR_STATUS     = 8'h0C;
  // Field positions
  localparam int SPECIAL_FLAG_BIT = 0;
  localparam int MODE_A_FLAG_BIT  = 1;
  localparam int WDOG_DIS_BIT     = 3;
  // Reset values
  localparam logic [7:0] FACT_TEST_RST = 8'h00;
  localparam logic [7:0] PRIV_CTRL_RST = 8'h00;
  // Vector map
  localparam logic [15:0] PSEUDO_VEC_FIRST = 16'h00B5;
  localparam logic [15:0] PSEUDO_VEC_LAST  = 16'h00FD;
  localparam logic [15:0] PSEUDO_VEC_STEP  = 16'h0003;
  localparam logic [15:0] BOOT_RESET_VEC   = 16'hBF40;
  localparam logic [15:0] TEST_VEC         = 16'hBFFE;
  localparam logic [15:0] RAM_ENTRY        = 16'h0000;
  localparam logic [4:0]  VEC_RESET_IDX    = 5'h19;
  // Serial timing in E-clock ticks
  localparam int BIT_TICKS  = 16;
  localparam int CHAR_BITS  = 10;
  localparam int IDLE_CHARS = 4;
  localparam int IDLE_TICKS = IDLE_CHARS * CHAR_BITS * BIT_TICKS;
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  // Operating modes, coded as {special flag, mode A flag}
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_EXPAND = 2'b01,
    MODE_BOOT   = 2'b10,
    MODE_TEST   = 2'b11
  } op_mode_t;
  // Bootstrap loader states
  typedef enum logic [1:0] {
    BOOT_OFF   = 2'b00,
    BOOT_BREAK = 2'b01,
    BOOT_LOAD  = 2'b10,
    BOOT_DONE  = 2'b11
  } boot_state_t;
  // Core request towards the external bus
  typedef struct packed {
    logic        valid;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpu_req_t;
endpackage

// [core/operating_mode_select.sv]
// Operating mode selector: strap capture, mode register, external bus, vectors and bootstrap loader
`timescale 1ns/1ps
// Notes on behaviour
// - Both mode straps are sampled during reset into the mode flags.
// - Straps A,B: 01 single, 11 expanded, 00 bootstrap, 10 test; special = not B.
// - Single chip drives no external bus and keeps read/write high.
// - Expanded mode puts address on ports B and F, data on port C.
// - Bootstrap serial runs at E-clock divided by sixteen.
// - Bootstrap sends a break on the serial transmitter after reset.
// - The first all-ones byte is not echoed on the transmitter.
// - Loader fills RAM, then jumps to 0000 after four idle characters.
// - In bootstrap every vector except reset resolves to a three-byte RAM pseudo-vector.
// - Pseudo-vectors 00B5 to 00FD at three-byte steps; reset vector BF40.
// - Bootstrap fetches all vectors from the on-chip bootstrap ROM.
// - Reset into bootstrap sets the special flag to one.
// - Privileged control bits are writable only while the special flag is set.
// - Software changes mode by writing special and mode A flags.
// - Test mode fetches reset and interrupt vectors externally at BFFE-BFFF.
// - Test mode enables the factory test register.
// - Clearing the special flag is one-way until the next reset.
// - Factory test register writable while special, reads zero outside test.
// - Watchdog-reset disable bit resets to one in special modes, else zero.
// - Read/write line stays high in bootstrap mode too.
module operating_mode_select
  import mode_sel_pkg::*;
#(
  parameter int          E_DIV           = 4,
  parameter logic [15:0] NORMAL_VEC_BASE = 16'hFFCE
) (
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        mode_strap_a_in,
  input  wire logic        mode_strap_b_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire cpu_req_t    cpu_req_in,
  output logic [7:0]       cpu_rdata_out,
  output logic [7:0]       port_b_addr_out,
  output logic [7:0]       port_f_addr_out,
  input  wire logic [7:0]  port_c_data_in,
  output logic [7:0]       port_c_data_out,
  output logic             port_c_data_oe_out,
  output logic             rw_n_out,
  input  wire logic        vec_req_in,
  input  wire logic [4:0]  vec_idx_in,
  output logic [15:0]      vec_addr_out,
  output logic             vec_boot_rom_out,
  output logic             vec_external_out,
  input  wire logic        serial_rx_in,
  output logic             serial_tx_out,
  output logic [15:0]      ram_addr_out,
  output logic [7:0]       ram_wdata_out,
  output logic             ram_we_out,
  output logic             boot_jump_out,
  output logic [15:0]      boot_jump_addr_out,
  output logic             disable_watchdog_resets_out,
  output logic [7:0]       factory_test_out,
  output logic [7:0]       priv_ctrl_out
);

  // Pin synchronisers; only the second stage is read by logic
  logic [1:0] strap_a_sync_q, strap_b_sync_q, rx_sync_q;
  logic [7:0] port_c_sync1_q, port_c_sync2_q;
  wire        strap_a_s = strap_a_sync_q[1];
  wire        strap_b_s = strap_b_sync_q[1];
  wire        rx_s      = rx_sync_q[1];
  always_ff @(posedge core_clk_in) begin
    strap_a_sync_q <= {strap_a_sync_q[0], mode_strap_a_in};
    strap_b_sync_q <= {strap_b_sync_q[0], mode_strap_b_in};
    rx_sync_q      <= {rx_sync_q[0], serial_rx_in};
    port_c_sync1_q <= port_c_data_in;
    port_c_sync2_q <= port_c_sync1_q;
  end

  // Mode flags and privileged registers
  logic        special_q, mode_a_q, wdog_dis_q;
  logic [7:0]  fact_test_q, priv_ctrl_q;
  op_mode_t    mode;
  assign mode = op_mode_t'({special_q, mode_a_q});
  wire         is_test = (mode == MODE_TEST);

  // APB decode: one wait state, write commits at the edge that sees pready
  logic        pready_q, pslverr_q;
  logic [31:0] prdata_q;
  wire         apb_access = psel_in && penable_in;
  wire         apb_commit = apb_access && pready_q;
  wire         apb_wr     = apb_commit && pwrite_in;
  wire         hit_prio   = (paddr_in == ADDR_PRIO_MODE);
  wire         hit_fact   = (paddr_in == ADDR_FACT_TEST);
  wire         hit_priv   = (paddr_in == ADDR_PRIV_CTRL);
  wire         hit_stat   = (paddr_in == ADDR_STATUS);
  wire         hit_any    = hit_prio || hit_fact || hit_priv || hit_stat;
  wire [7:0]   wbyte      = pwdata_in[7:0];

  // Mode flag update; privilege is judged by the flag before the write
  wire special_d = (apb_wr && hit_prio && !wbyte[SPECIAL_FLAG_BIT]) ? 1'b0 : special_q;
  wire mode_a_d  = (apb_wr && hit_prio && special_q) ? wbyte[MODE_A_FLAG_BIT] : mode_a_q;
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      special_q <= !strap_b_s;
      mode_a_q  <= strap_a_s;
    end else begin
      special_q <= special_d;
      mode_a_q  <= mode_a_d;
    end
  end

  // Factory test and privileged control registers
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      fact_test_q <= FACT_TEST_RST;
      wdog_dis_q  <= !strap_b_s;
      priv_ctrl_q <= PRIV_CTRL_RST;
    end else begin
      if (apb_wr && hit_fact && special_q) begin
        fact_test_q <= wbyte;
        wdog_dis_q  <= wbyte[WDOG_DIS_BIT];
      end
      if (apb_wr && hit_priv && special_q) begin
        priv_ctrl_q <= wbyte;
      end
    end
  end

  // Read data view; factory test bits vanish outside test mode
  logic [7:0] fact_view, rd_byte;
  boot_state_t boot_state_q;
  logic        rx_busy_q;
  always_comb begin
    fact_view = fact_test_q;
    fact_view[WDOG_DIS_BIT] = wdog_dis_q;
    rd_byte = 8'h00;
    if (hit_prio) rd_byte = {6'h00, mode_a_q, special_q};
    if (hit_fact) rd_byte = is_test ? fact_view : 8'h00;
    if (hit_priv) rd_byte = priv_ctrl_q;
    if (hit_stat) rd_byte = {3'h0, rx_busy_q, boot_state_q, mode};
  end

  // Pin view of the factory test bits; registered, so it trails the register by one cycle
  logic [7:0] fact_out_q;
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) fact_out_q <= 8'h00;
    else fact_out_q <= is_test ? fact_view : 8'h00;
  end

  // APB handshake
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (apb_access && !pready_q) begin
      pready_q  <= 1'b1;
      pslverr_q <= !hit_any;
      prdata_q  <= {24'h00_0000, rd_byte};
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // External bus; only expanded and test modes drive it
  logic [7:0] addr_hi_q, addr_lo_q, data_out_q, rdata_q;
  logic       data_oe_q, rw_n_q;
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      addr_hi_q  <= 8'h00;
      addr_lo_q  <= 8'h00;
      data_out_q <= 8'h00;
      data_oe_q  <= 1'b0;
      rw_n_q     <= 1'b1;
      rdata_q    <= 8'h00;
    end else if (!mode_a_q) begin
      addr_hi_q <= 8'h00;
      addr_lo_q <= 8'h00;
      data_oe_q <= 1'b0;
      rw_n_q    <= 1'b1;
    end else if (cpu_req_in.valid) begin
      addr_hi_q  <= cpu_req_in.addr[15:8];
      addr_lo_q  <= cpu_req_in.addr[7:0];
      data_out_q <= cpu_req_in.wdata;
      data_oe_q  <= cpu_req_in.we;
      rw_n_q     <= !cpu_req_in.we;
      rdata_q    <= port_c_sync2_q;
    end else begin
      data_oe_q <= 1'b0;
      rw_n_q    <= 1'b1;
      rdata_q   <= port_c_sync2_q;
    end
  end

  // Vector resolution
  logic [15:0] vec_addr_q, vec_next;
  logic        vec_rom_q, vec_ext_q;
  always_comb begin
    vec_next = NORMAL_VEC_BASE + {10'h000, vec_idx_in, 1'b0};
    if (mode == MODE_BOOT) begin
      vec_next = (vec_idx_in == VEC_RESET_IDX) ? BOOT_RESET_VEC
               : 16'(PSEUDO_VEC_FIRST + PSEUDO_VEC_STEP * 16'(vec_idx_in));
    end else if (is_test) begin
      vec_next = TEST_VEC;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      vec_addr_q <= 16'h0000;
      vec_rom_q  <= 1'b0;
      vec_ext_q  <= 1'b0;
    end else if (vec_req_in) begin
      vec_addr_q <= vec_next;
      vec_rom_q  <= (mode == MODE_BOOT);
      vec_ext_q  <= is_test;
    end
  end

  // E-clock enable from the core clock
  logic [7:0] e_div_q;
  wire        e_tick = (e_div_q == 8'(E_DIV - 1));
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || e_tick) e_div_q <= 8'h00;
    else e_div_q <= e_div_q + 8'h01;
  end

  // Serial receiver, sixteen E ticks per bit, sampled at mid-bit
  logic [3:0] rx_cnt_q, rx_bit_q;
  logic [7:0] rx_shift_q;
  logic       rx_done_q;
  wire        rx_sample = e_tick && rx_busy_q && (rx_cnt_q == 4'h0);
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rx_busy_q  <= 1'b0;
      rx_cnt_q   <= 4'h0;
      rx_bit_q   <= 4'h0;
      rx_shift_q <= 8'h00;
      rx_done_q  <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (e_tick && !rx_busy_q && !rx_s) begin
        rx_busy_q <= 1'b1;
        rx_cnt_q  <= 4'h7;
        rx_bit_q  <= 4'h0;
      end else if (rx_sample) begin
        rx_cnt_q <= 4'(BIT_TICKS - 1);
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && rx_s) rx_busy_q <= 1'b0;  // False start
        else if (rx_bit_q == 4'(CHAR_BITS - 1)) begin
          rx_busy_q <= 1'b0;
          rx_done_q <= 1'b1;
        end else if (rx_bit_q != 4'h0) rx_shift_q <= {rx_s, rx_shift_q[7:1]};
      end else if (e_tick && rx_busy_q) rx_cnt_q <= rx_cnt_q - 4'h1;
    end
  end

  // Bootstrap loader; a slow E/104 sync byte just looks like one odd first character
  logic [15:0] ram_ptr_q, idle_cnt_q, ram_addr_q;
  logic        ram_we_q, jump_q, tx_q;
  wire         line_idle = !rx_busy_q && rx_s && (ram_ptr_q != RAM_ENTRY);
  wire         idle_end  = e_tick && line_idle && (idle_cnt_q == 16'(IDLE_TICKS - 1));
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      boot_state_q <= (!strap_b_s && !strap_a_s) ? BOOT_BREAK : BOOT_OFF;
      ram_ptr_q    <= RAM_ENTRY;
      ram_addr_q   <= RAM_ENTRY;
      idle_cnt_q   <= 16'h0000;
      ram_we_q     <= 1'b0;
      jump_q       <= 1'b0;
      tx_q         <= 1'b1;
    end else begin
      ram_we_q <= 1'b0;
      jump_q   <= 1'b0;
      tx_q     <= (boot_state_q != BOOT_BREAK);
      if (!line_idle) idle_cnt_q <= 16'h0000;
      else if (e_tick) idle_cnt_q <= idle_cnt_q + 16'h0001;
      case (boot_state_q)
        BOOT_BREAK: if (rx_done_q) boot_state_q <= BOOT_LOAD;
        BOOT_LOAD: begin
          if (rx_done_q) begin
            ram_we_q  <= 1'b1;
            ram_addr_q <= ram_ptr_q;
            ram_ptr_q <= ram_ptr_q + 16'h0001;
          end
          if (idle_end) begin
            boot_state_q <= BOOT_DONE;
            jump_q       <= 1'b1;
          end
        end
        BOOT_OFF, BOOT_DONE: boot_state_q <= boot_state_q;
        default: boot_state_q <= BOOT_OFF;
      endcase
    end
  end

  // Outputs, all from flops except the constant boot_jump_addr_out
  assign prdata_out                  = prdata_q;
  assign pready_out                  = pready_q;
  assign pslverr_out                 = pslverr_q;
  assign cpu_rdata_out               = rdata_q;
  assign port_b_addr_out             = addr_hi_q;
  assign port_f_addr_out             = addr_lo_q;
  assign port_c_data_out             = data_out_q;
  assign port_c_data_oe_out          = data_oe_q;
  assign rw_n_out                    = rw_n_q;
  assign vec_addr_out                = vec_addr_q;
  assign vec_boot_rom_out            = vec_rom_q;
  assign vec_external_out            = vec_ext_q;
  assign serial_tx_out               = tx_q;
  assign ram_addr_out                = ram_addr_q;
  assign ram_wdata_out               = rx_shift_q;
  assign ram_we_out                  = ram_we_q;
  assign boot_jump_out               = jump_q;
  assign boot_jump_addr_out          = RAM_ENTRY;
  assign disable_watchdog_resets_out = wdog_dis_q;
  assign factory_test_out            = fact_out_q;
  assign priv_ctrl_out               = priv_ctrl_q;

  // Checks
  property p_strap_latch;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(reset_n_in) |-> (special_q == !$past(strap_b_s)) && (mode_a_q == $past(strap_a_s));
  endproperty
  a_strap_latch: assert property (p_strap_latch) else $error("mode flags not strap levels");
  property p_wdog_dis_init;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    $rose(reset_n_in) |-> wdog_dis_q == special_q;
  endproperty
  a_wdog_dis_init: assert property (p_wdog_dis_init) else $error("watchdog disable reset value wrong");
  property p_rw_high;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (!mode_a_q && $past(!mode_a_q)) |-> rw_n_out && !port_c_data_oe_out;
  endproperty
  a_rw_high: assert property (p_rw_high) else $error("bus driven outside expanded modes");
  property p_exp_addr;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (mode_a_q && cpu_req_in.valid) |=> {port_b_addr_out, port_f_addr_out} == $past(cpu_req_in.addr)
      && rw_n_out == !$past(cpu_req_in.we);
  endproperty
  a_exp_addr: assert property (p_exp_addr) else $error("expanded address not on ports");
  property p_break;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    // The release edge itself still loads the idle level, so the break is only owed one cycle later
    (reset_n_in && boot_state_q == BOOT_BREAK) ##1 (boot_state_q == BOOT_BREAK) |-> !serial_tx_out;
  endproperty
  a_break: assert property (p_break) else $error("no break during bootstrap wait");
  property p_no_echo;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (boot_state_q == BOOT_BREAK && rx_done_q) |=> !ram_we_out && boot_state_q == BOOT_LOAD ##1 serial_tx_out;
  endproperty
  a_no_echo: assert property (p_no_echo) else $error("sync byte handled wrongly");
  property p_load;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (boot_state_q == BOOT_LOAD && rx_done_q) |=> ram_we_out && ram_wdata_out == $past(rx_shift_q);
  endproperty
  a_load: assert property (p_load) else $error("received byte not written to RAM");
  property p_jump;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    idle_end |=> boot_jump_out && boot_jump_addr_out == 16'h0000 && boot_state_q == BOOT_DONE;
  endproperty
  a_jump: assert property (p_jump) else $error("no jump after idle line");
  property p_pseudo_vec;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (vec_req_in && mode == MODE_BOOT && vec_idx_in == 5'h18) |=> vec_addr_out == PSEUDO_VEC_LAST && vec_boot_rom_out;
  endproperty
  a_pseudo_vec: assert property (p_pseudo_vec) else $error("last pseudo-vector wrong");
  property p_special_oneway;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    !special_q |=> !special_q && $stable(fact_test_q);
  endproperty
  a_special_oneway: assert property (p_special_oneway) else $error("special flag set again");
  property p_fact_hidden;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    !is_test |=> factory_test_out == 8'h00;
  endproperty
  a_fact_hidden: assert property (p_fact_hidden) else $error("factory test bits visible outside test");
  property p_e16;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    rx_sample |=> rx_cnt_q == 4'hF;
  endproperty
  a_e16: assert property (p_e16) else $error("bit period not sixteen E ticks");
  c_boot_done: cover property (@(posedge core_clk_in) boot_jump_out);
  c_special_clear: cover property (@(posedge core_clk_in) $fell(special_q));
  c_test_vec: cover property (@(posedge core_clk_in) vec_external_out);
  c_ext_write: cover property (@(posedge core_clk_in) port_c_data_oe_out);

endmodule

// [dv/mode_host_model.sv]
// Board-side partner: mode strap pins and serial download host
`timescale 1ns/1ps
module mode_host_model
  import mode_sel_pkg::*;
#(
  parameter int E_DIV = 4
) (
  input  wire logic core_clk_in,
  output logic      mode_strap_a_out,
  output logic      mode_strap_b_out,
  output logic      serial_rx_out
);
  // Line idles at mark; straps start at a normal mode until a scenario picks one
  initial begin
    mode_strap_a_out = 1'b1;
    mode_strap_b_out = 1'b1;
    serial_rx_out    = 1'b1;
  end
  // Straps move just after an edge; the device only honours them while reset is low
  task automatic set_straps(input logic a, input logic b);
    @(posedge core_clk_in);
    mode_strap_a_out <= a;
    mode_strap_b_out <= b;
  endtask
  // One 8N1 character, least significant bit first, bit time of sixteen E ticks
  task automatic send_byte(input logic [7:0] data);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_in);
      serial_rx_out <= frame[i];
      repeat (BIT_TICKS * E_DIV - 1) @(posedge core_clk_in);
    end
  endtask
  // A download always opens with the all-ones byte
  task automatic send_sync();
    send_byte(SYNC_BYTE);
  endtask
endmodule

// [dv/operating_mode_select_tb.sv]
// Self-checking bench for the operating mode selector
`timescale 1ns/1ps
module operating_mode_select_tb;
  import mode_sel_pkg::*;
  localparam int          E_DIV    = 4;
  localparam logic [15:0] NORM_VEC = 16'hFFCE;
  localparam int          IDLE_CYC = 4 * 10 * 16 * E_DIV;
  logic        core_clk_in = 1'b0;
  logic        reset_n_in  = 1'b0;
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, vec_req_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00, port_c_data_in = 8'hC3;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [4:0]  vec_idx_in = 5'h00;
  cpu_req_t    cpu_req_in = '0;
  logic        mode_strap_a_in, mode_strap_b_in, serial_rx_in;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, port_c_data_oe_out, rw_n_out, vec_boot_rom_out, vec_external_out;
  logic        serial_tx_out, ram_we_out, boot_jump_out, disable_watchdog_resets_out;
  logic [7:0]  cpu_rdata_out, port_b_addr_out, port_f_addr_out, port_c_data_out, ram_wdata_out;
  logic [7:0]  factory_test_out, priv_ctrl_out;
  logic [15:0] vec_addr_out, ram_addr_out, boot_jump_addr_out, jump_addr;
  int          n_mismatch = 0, comparisons = 0, n_jump = 0;
  logic [15:0] wr_addr[$];
  logic [7:0]  wr_data[$];

  always #5 core_clk_in = ~core_clk_in;

  operating_mode_select #(.E_DIV(E_DIV), .NORMAL_VEC_BASE(NORM_VEC)) operating_mode_select_i (
    .core_clk_in, .reset_n_in, .mode_strap_a_in, .mode_strap_b_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .cpu_req_in, .cpu_rdata_out,
    .port_b_addr_out, .port_f_addr_out, .port_c_data_in, .port_c_data_out, .port_c_data_oe_out, .rw_n_out,
    .vec_req_in, .vec_idx_in, .vec_addr_out, .vec_boot_rom_out, .vec_external_out, .serial_rx_in,
    .serial_tx_out, .ram_addr_out, .ram_wdata_out, .ram_we_out, .boot_jump_out, .boot_jump_addr_out,
    .disable_watchdog_resets_out, .factory_test_out, .priv_ctrl_out);

  mode_host_model #(.E_DIV(E_DIV)) mode_host_model_i (
    .core_clk_in, .mode_strap_a_out(mode_strap_a_in), .mode_strap_b_out(mode_strap_b_in),
    .serial_rx_out(serial_rx_in));

  // Loader pulses last one cycle, so sample them once per cycle where settled
  always @(negedge core_clk_in) begin
    if (ram_we_out === 1'b1) begin
      wr_addr.push_back(ram_addr_out);
      wr_data.push_back(ram_wdata_out);
    end
    if (boot_jump_out === 1'b1) begin
      n_jump++;
      jump_addr = boot_jump_addr_out;
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // APB master: request held until the edge that sees pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge core_clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= wr;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    // Read at the rising edge, where pready_out still shows its pre-edge value
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk_in);
      if (pready_out === 1'b1) break;
    end
    if (i == 20) begin
      $display("MISMATCH pready expected 1 seen timeout");
      n_mismatch++;
      summarize();
    end
    rd  = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic apb_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check(what, exp, rd & m);
  endtask

  // Straps are set ahead of a twelve-cycle reset
  task automatic reset_into(input logic a, input logic b);
    mode_host_model_i.set_straps(a, b);
    @(posedge core_clk_in);
    reset_n_in <= 1'b0;
    repeat (12) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
  endtask

  // Core bus request for one cycle; returns where the answer has settled
  task automatic cpu_cyc(input logic we, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    cpu_req_in <= '{valid: 1'b1, we: we, addr: a, wdata: d};
    @(posedge core_clk_in);
    cpu_req_in <= '0;
    @(negedge core_clk_in);
  endtask

  task automatic vec_chk(input logic [1:0] c, input logic [4:0] idx);
    logic [15:0] exp;
    exp = (c == 2'b10) ? ((idx == 5'h19) ? 16'hBF40 : 16'h00B5 + 16'(idx) * 16'h0003)
        : (c == 2'b11) ? 16'hBFFE : NORM_VEC + 16'(idx) * 16'h0002;
    @(posedge core_clk_in);
    vec_req_in <= 1'b1;
    vec_idx_in <= idx;
    @(posedge core_clk_in);
    vec_req_in <= 1'b0;
    @(negedge core_clk_in);
    check("vec_addr", 32'(exp), 32'(vec_addr_out));
    check("vec_rom", 32'(c == 2'b10), 32'(vec_boot_rom_out));
    check("vec_ext", 32'(c == 2'b11), 32'(vec_external_out));
  endtask

  // Every strap pair; straps are flipped after release to show they are no longer followed
  task automatic t_strap_modes();
    logic [1:0] c;
    for (int m = 0; m < 4; m++) begin
      c = 2'(m);
      reset_into(c[0], ~c[1]);
      mode_host_model_i.set_straps(~c[0], c[1]);
      repeat (4) @(posedge core_clk_in);
      apb_chk("mode_flags", ADDR_STATUS, 32'h3, 32'(c));
      check("wdog_disable", 32'(c[1]), 32'(disable_watchdog_resets_out));
      if (!c[0]) begin
        cpu_cyc(1'b1, 16'h1234, 8'h5A);
        check("idle_oe", 32'h0, 32'(port_c_data_oe_out));
        check("idle_rw_n", 32'h1, 32'(rw_n_out));
        check("idle_addr", 32'h0, 32'(port_b_addr_out));
      end
      vec_chk(c, 5'h00);
      vec_chk(c, 5'h18);
      vec_chk(c, 5'h19);
    end
  endtask

  task automatic t_expanded();
    reset_into(1'b1, 1'b1);
    cpu_cyc(1'b1, 16'h1234, 8'h5A);
    check("wr_addr", 32'h1234, 32'({port_b_addr_out, port_f_addr_out}));
    check("wr_data", 32'h5A, 32'(port_c_data_out));
    check("wr_oe_rw_n", 32'h2, 32'({port_c_data_oe_out, rw_n_out}));
    @(negedge core_clk_in);
    check("idle_oe_rw_n", 32'h1, 32'({port_c_data_oe_out, rw_n_out}));
    cpu_cyc(1'b0, 16'hABCD, 8'h00);
    check("rd_addr", 32'hABCD, 32'({port_b_addr_out, port_f_addr_out}));
    check("rd_oe_rw_n", 32'h1, 32'({port_c_data_oe_out, rw_n_out}));
    check("rd_data", 32'hC3, 32'(cpu_rdata_out));
  endtask

  // Privileged writes in test mode, then the one-way drop to a normal mode
  task automatic t_test_regs();
    logic [31:0] rd;
    logic        err;
    reset_into(1'b1, 1'b0);
    apb_wr(ADDR_FACT_TEST, 32'h0000_005A);
    apb_chk("fact_test", ADDR_FACT_TEST, 32'hFF, 32'h5A);
    check("fact_out", 32'h5A, 32'(factory_test_out));
    apb_wr(ADDR_PRIV_CTRL, 32'h0000_00A5);
    apb_chk("priv", ADDR_PRIV_CTRL, 32'hFF, 32'hA5);
    check("priv_out", 32'hA5, 32'(priv_ctrl_out));
    apb(1'b0, 8'h10, 32'h0000_0000, rd, err);
    check("unmapped_err", 32'h1, 32'(err));
    apb_wr(ADDR_PRIO_MODE, 32'h0000_0002);
    apb_chk("mode_cleared", ADDR_STATUS, 32'h3, 32'h1);
    apb_wr(ADDR_PRIO_MODE, 32'h0000_0003);
    apb_chk("mode_no_set", ADDR_STATUS, 32'h3, 32'h1);
    apb_chk("fact_normal", ADDR_FACT_TEST, 32'hFF, 32'h0);
    check("fact_out_normal", 32'h0, 32'(factory_test_out));
    apb_wr(ADDR_PRIV_CTRL, 32'h0000_0033);
    apb_chk("priv_locked", ADDR_PRIV_CTRL, 32'hFF, 32'hA5);
  endtask

  // Bootstrap download: break, silent sync byte, two stored bytes, jump after idle
  task automatic t_boot();
    int i;
    reset_into(1'b0, 1'b0);
    wr_addr.delete();
    wr_data.delete();
    n_jump = 0;
    repeat (4) @(negedge core_clk_in);
    check("break", 32'h0, 32'(serial_tx_out));
    mode_host_model_i.send_sync();
    repeat (8) @(negedge core_clk_in);
    check("sync_stored", 32'h0, 32'(wr_addr.size()));
    check("tx_quiet", 32'h1, 32'(serial_tx_out));
    mode_host_model_i.send_byte(8'hA5);
    mode_host_model_i.send_byte(8'h3C);
    for (i = 0; i < IDLE_CYC + 200 && n_jump == 0; i++) @(negedge core_clk_in);
    check("bytes_stored", 32'h2, 32'(wr_addr.size()));
    if (wr_addr.size() == 2) begin
      check("byte0", 32'h0000_00A5, 32'({wr_addr[0], wr_data[0]}));
      check("byte1", 32'h0000_013C, 32'({wr_addr[1], wr_data[1]}));
    end
    check("jump_once", 32'h1, 32'(n_jump));
    check("jump_addr", 32'h0, 32'(jump_addr));
    check("idle_time", 32'h1, 32'(i > IDLE_CYC - 100));
    apb_wr(ADDR_PRIO_MODE, 32'h0000_0003);
    apb_chk("boot_to_test", ADDR_STATUS, 32'h3, 32'h3);
  endtask

  initial begin
    t_strap_modes();
    t_expanded();
    t_test_regs();
    t_boot();
    summarize();
  end

  // Cut a hung run short
  initial begin
    repeat (100000) @(posedge core_clk_in);
    $display("MISMATCH run_length expected end seen timeout");
    n_mismatch++;
    summarize();
  end
endmodule
